// ==== pkg/aps_pkg.sv ====
package aps_pkg;

  // ***************************************************************
  // Register map (APB byte addresses)
  // ***************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SSI_CFG = 8'h04;
  localparam logic [7:0] ADDR_WINDOW = 8'h08;
  localparam logic [7:0] ADDR_JOG_VEL = 8'h0C;
  localparam logic [7:0] ADDR_MAX_VEL = 8'h10;
  localparam logic [7:0] ADDR_STROKE = 8'h14;
  localparam logic [7:0] ADDR_DECEL = 8'h18;
  localparam logic [7:0] ADDR_EMERGENCY_OUTPUT_VALUE = 8'h1C;
  localparam logic [7:0] ADDR_GAIN = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_ACT_POS = 8'h28;
  localparam logic [7:0] ADDR_CMD_POS = 8'h2C;

  // CTRL fields
  localparam int CTRL_ANA_FB = 0;
  localparam int CTRL_SPD_EXT = 1;
  localparam int CTRL_CUR_MODE = 2;
  localparam int CTRL_INVERT = 3;
  localparam int CTRL_NC_MODE = 4;
  localparam int CTRL_EMERGENCY_OUTPUT_VALUE_EN = 5;
  localparam int CTRL_GRAY = 6;

  // Field widths
  localparam int POS_W = 24;
  localparam int OUT_W = 16;
  localparam int ANA_W = 16;
  localparam int BITS_W = 5;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0020;
  localparam logic [31:0] SSI_CFG_RST = 32'h0000_0018;
  localparam logic [31:0] WINDOW_RST = 32'h0000_0064;
  localparam logic [31:0] JOG_VEL_RST = 32'h0000_1000;
  localparam logic [31:0] MAX_VEL_RST = 32'h0000_7FFF;
  localparam logic [31:0] STROKE_RST = 32'h000F_4240;
  localparam logic [31:0] DECEL_RST = 32'h0000_03E8;
  localparam logic [31:0] EMERGENCY_OUTPUT_VALUE_RST = 32'h0000_0000;
  localparam logic [31:0] GAIN_RST = 32'h0000_0008;

  // Timing: SSI bit rate 150 kBaud, half period in pclk cycles
  localparam int CLK_HZ = 200_000_000;
  localparam int SSI_BAUD = 150_000;
  localparam int SSI_HALF_CYC = CLK_HZ / (2 * SSI_BAUD);
  localparam int SSI_MONO_CYC = 4 * SSI_HALF_CYC;
  localparam int SSI_TMO_CYC = 8 * SSI_HALF_CYC;
  localparam int SSI_CNT_W = 13;

  // Output scaling: full scale signed code, current 4..20 mA code
  localparam logic [OUT_W-1:0] MA4_CODE = 16'h3333;
  localparam logic [OUT_W-1:0] MA_SPAN_CODE = 16'hCCCC;
  localparam logic [ANA_W-1:0] CABLE_MIN = 16'h0800;
  localparam logic signed [OUT_W-1:0] OUT_MAX = 16'sh7FFF;
  localparam logic signed [OUT_W-1:0] OUT_MIN = -16'sh7FFF;

  typedef enum logic [1:0] {
    APS_IDLE = 2'b00,
    APS_CLK_LO = 2'b01,
    APS_CLK_HI = 2'b10,
    APS_MONO = 2'b11
  } aps_ssi_e;

  typedef enum logic [1:0] {
    APS_OFF = 2'b00,
    APS_HOLD = 2'b01,
    APS_JOG = 2'b10,
    APS_RUN = 2'b11
  } aps_mode_e;

  typedef struct packed {
    logic enable;
    logic start;
    logic jog_pos;
    logic jog_neg;
  } aps_din_s;

  typedef struct packed {
    logic signed [OUT_W-1:0] valve;
    logic [OUT_W-1:0] current;
    logic [OUT_W-1:0] monitor;
    logic current_mode;
    logic valve_active;
  } aps_aout_s;

endpackage : aps_pkg

// ==== src/aps_axis_seq.sv ====
// Summary of operation
// - Ready is high only while enable is on and feedback has no error.
// - In-position drops when position error exceeds the in-position window.
// - In-position is held low while start is off.
// - With start off, jog inputs move the axis at jog velocity.
// - On jog release, target takes the measured position and holds there.
// - With start on, target follows the analogue position command.
// - Start removed while moving: target is actual plus decel stroke ahead.
// - Enable initialises the controller and activates the valve output.
// - Enable copies measured position to target, closed loop begins.
// - Serial receiver has configurable bit count, Gray/binary, scaling.
// - Serial link is SSI at 150 kBaud.
// - Position counts are one micrometre per LSB.
// - Speed command is 0 to 100 percent of maximum velocity.
// - Position command is 0 to 100 percent of configured stroke.
// - Voltage mode maps signed full scale to signed output code.
// - Current mode maps minus..plus full scale onto 4..20 mA code.
// - CTRL_CUR_MODE selects current/voltage, CTRL_INVERT selects polarity.
// - Monitor output shows measured position scaled 0 to 10 V.
// - Analogue feedback may replace the serial sensor.
// - Velocity limit from internal setting or speed command.
// - Broken command cable and sensor fault are reported as errors.
// - Two control modes: stroke decel gain, or profile following.
// - On sensor failure the valve output is forced to the emergency value.
//
// The APB slave port and the register offsets are this design's own decisions.
module aps_axis_seq
  import aps_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire aps_din_s din,
  input wire logic [ANA_W-1:0] position_command_input,
  input wire logic [ANA_W-1:0] speed_cmd,
  input wire logic [ANA_W-1:0] ana_feedback,
  input wire logic ssi_data,
  output logic ssi_clk,
  output logic ready,
  output logic in_position,
  output aps_aout_s aout,
  output logic cmd_cable_err,
  output logic sensor_err
);

  // ***************************************************************
  // Register file
  // ***************************************************************
  logic [31:0] ctrl_r, ssi_cfg_r, window_r, jog_vel_r, max_vel_r;
  logic [31:0] stroke_r, decel_r, emergency_output_value_r, gain_r;
  logic [POS_W-1:0] act_pos_r, cmd_pos_r;
  aps_mode_e mode_r;
  logic wr_en;
  logic mapped;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;

  always_comb
  begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_CTRL: prdata = ctrl_r;
      ADDR_SSI_CFG: prdata = ssi_cfg_r;
      ADDR_WINDOW: prdata = window_r;
      ADDR_JOG_VEL: prdata = jog_vel_r;
      ADDR_MAX_VEL: prdata = max_vel_r;
      ADDR_STROKE: prdata = stroke_r;
      ADDR_DECEL: prdata = decel_r;
      ADDR_EMERGENCY_OUTPUT_VALUE: prdata = emergency_output_value_r;
      ADDR_GAIN: prdata = gain_r;
      ADDR_STATUS: prdata = {26'h0, mode_r, cmd_cable_err, sensor_err, in_position, ready};
      ADDR_ACT_POS: prdata = {8'h00, act_pos_r};
      ADDR_CMD_POS: prdata = {8'h00, cmd_pos_r};
      default: mapped = 1'b0;
    endcase
  end

  // Unmapped addresses answer with an error, writes to them are dropped
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= CTRL_RST;
      ssi_cfg_r <= SSI_CFG_RST;
      window_r <= WINDOW_RST;
      jog_vel_r <= JOG_VEL_RST;
      max_vel_r <= MAX_VEL_RST;
      stroke_r <= STROKE_RST;
      decel_r <= DECEL_RST;
      emergency_output_value_r <= EMERGENCY_OUTPUT_VALUE_RST;
      gain_r <= GAIN_RST;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        ADDR_CTRL: ctrl_r <= pwdata;
        ADDR_SSI_CFG: ssi_cfg_r <= pwdata;
        ADDR_WINDOW: window_r <= pwdata;
        ADDR_JOG_VEL: jog_vel_r <= pwdata;
        ADDR_MAX_VEL: max_vel_r <= pwdata;
        ADDR_STROKE: stroke_r <= pwdata;
        ADDR_DECEL: decel_r <= pwdata;
        ADDR_EMERGENCY_OUTPUT_VALUE: emergency_output_value_r <= pwdata;
        ADDR_GAIN: gain_r <= pwdata;
        default: ;
      endcase
    end
  end

  // ***************************************************************
  // Input synchronisers
  // ***************************************************************
  aps_din_s din_m, din_s;
  logic sdat_m, sdat_s;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      din_m <= '0;
      din_s <= '0;
      sdat_m <= 1'b1;
      sdat_s <= 1'b1;
    end
    else
    begin
      din_m <= din;
      din_s <= din_m;
      sdat_m <= ssi_data;
      sdat_s <= sdat_m;
    end
  end

  // ***************************************************************
  // SSI master
  // ***************************************************************
  aps_ssi_e ssi_st_r;
  logic [SSI_CNT_W-1:0] tick_r;
  logic [BITS_W-1:0] bit_r;
  logic [POS_W-1:0] shift_r;
  logic [POS_W-1:0] raw_pos_r;
  logic frame_done_r;
  logic [SSI_CNT_W-1:0] idle_r;
  logic [BITS_W-1:0] nbits;
  logic half_tick;

  assign nbits = ssi_cfg_r[BITS_W-1:0];
  assign half_tick = (tick_r == SSI_CNT_W'(SSI_HALF_CYC - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ssi_st_r <= APS_IDLE;
      tick_r <= '0;
      bit_r <= '0;
      shift_r <= '0;
      raw_pos_r <= '0;
      frame_done_r <= 1'b0;
      ssi_clk <= 1'b1;
    end
    else
    begin
      frame_done_r <= 1'b0;
      tick_r <= half_tick ? '0 : tick_r + 1'b1;
      unique case (ssi_st_r)
        APS_IDLE:
        begin
          ssi_clk <= 1'b1;
          if (half_tick)
          begin
            ssi_st_r <= APS_CLK_LO;
            bit_r <= nbits;
            shift_r <= '0;
            ssi_clk <= 1'b0;
          end
        end
        APS_CLK_LO:
          if (half_tick)
          begin
            ssi_clk <= 1'b1;
            ssi_st_r <= APS_CLK_HI;
          end
        APS_CLK_HI:
          if (half_tick)
          begin
            // Sensor shifts on rising edge; sample before next falling edge
            shift_r <= {shift_r[POS_W-2:0], sdat_s};
            bit_r <= bit_r - 1'b1;
            if (bit_r == BITS_W'(1))
            begin
              ssi_st_r <= APS_MONO;
              tick_r <= '0;
            end
            else
            begin
              ssi_clk <= 1'b0;
              ssi_st_r <= APS_CLK_LO;
            end
          end
        APS_MONO:
          // Clock rests high while the sensor monoflop times out
          if (tick_r == SSI_CNT_W'(SSI_MONO_CYC - 1))
          begin
            raw_pos_r <= shift_r;
            frame_done_r <= 1'b1;
            ssi_st_r <= APS_IDLE;
            tick_r <= '0;
          end
          else
            tick_r <= tick_r + 1'b1;
        default: ssi_st_r <= APS_IDLE;
      endcase
    end
  end

  // Gray decode per bit: each bit is xor of that bit and all higher bits
  logic [POS_W-1:0] gray_bin;
  genvar g;
  generate
    for (g = 0; g < POS_W; g++)
    begin : g_gray
      assign gray_bin[g] = ^(raw_pos_r >> g);
    end
  endgenerate

  // Sensor fault: line low through the rest phases; counting pauses in frames, so zero data is no fault
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idle_r <= '0;
    else if (sdat_s && ssi_st_r inside {APS_IDLE, APS_MONO})
      idle_r <= '0;
    else if (idle_r != SSI_CNT_W'(SSI_TMO_CYC) && ssi_st_r inside {APS_IDLE, APS_MONO})
      idle_r <= idle_r + 1'b1;
  end

  // ***************************************************************
  // Actual position and errors
  // ***************************************************************
  logic [POS_W-1:0] ser_pos, ana_pos, cmd_target;
  logic [POS_W+ANA_W-1:0] ana_prod, cmd_prod;

  // Resolution scaling is a right shift from SSI_CFG[12:8]; 1 um per LSB
  assign ser_pos = (ctrl_r[CTRL_GRAY] ? gray_bin : raw_pos_r) >> ssi_cfg_r[12:8];
  assign ana_prod = stroke_r[POS_W-1:0] * ana_feedback;
  assign ana_pos = ana_prod[POS_W+ANA_W-1:ANA_W];
  assign cmd_prod = stroke_r[POS_W-1:0] * position_command_input;
  assign cmd_target = cmd_prod[POS_W+ANA_W-1:ANA_W];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_pos_r <= '0;
      sensor_err <= 1'b0;
      cmd_cable_err <= 1'b0;
    end
    else
    begin
      if (ctrl_r[CTRL_ANA_FB])
        act_pos_r <= ana_pos;
      else if (frame_done_r)
        act_pos_r <= ser_pos;
      sensor_err <= ctrl_r[CTRL_ANA_FB] ? (ana_feedback < CABLE_MIN)
                  : (idle_r == SSI_CNT_W'(SSI_TMO_CYC));
      cmd_cable_err <= din_s.start && (position_command_input < CABLE_MIN);
    end
  end

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  logic signed [POS_W:0] pos_err;
  logic [POS_W-1:0] abs_err;
  logic jog_any, moving;
  logic signed [OUT_W-1:0] ctl_out_r;

  assign pos_err = $signed({1'b0, cmd_pos_r}) - $signed({1'b0, act_pos_r});
  assign abs_err = pos_err[POS_W] ? POS_W'(-pos_err) : pos_err[POS_W-1:0];
  assign jog_any = din_s.jog_pos ^ din_s.jog_neg;
  assign moving = (ctl_out_r != '0);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r <= APS_OFF;
      cmd_pos_r <= '0;
    end
    else if (!din_s.enable || sensor_err)
      mode_r <= APS_OFF;
    else
    begin
      unique case (mode_r)
        APS_OFF:
        begin
          cmd_pos_r <= act_pos_r;
          mode_r <= APS_HOLD;
        end
        APS_HOLD:
          if (din_s.start)
            mode_r <= APS_RUN;
          else if (jog_any)
            mode_r <= APS_JOG;
        APS_JOG:
          if (din_s.start || !jog_any)
          begin
            cmd_pos_r <= act_pos_r;
            mode_r <= din_s.start ? APS_RUN : APS_HOLD;
          end
        APS_RUN:
          if (din_s.start)
            cmd_pos_r <= cmd_target;
          else
          begin
            if (moving)
              cmd_pos_r <= ctl_out_r[OUT_W-1] ? act_pos_r - decel_r[POS_W-1:0]
                                              : act_pos_r + decel_r[POS_W-1:0];
            else
              cmd_pos_r <= act_pos_r;
            mode_r <= APS_HOLD;
          end
        default: mode_r <= APS_OFF;
      endcase
    end
  end

  // ***************************************************************
  // Control law and velocity limit
  // ***************************************************************
  logic [OUT_W-1:0] vlim;
  logic [OUT_W+ANA_W-1:0] spd_prod;
  logic signed [POS_W+8:0] p_term;
  logic signed [POS_W+8:0] p_sdd;
  logic signed [OUT_W-1:0] p_clip;

  assign spd_prod = max_vel_r[OUT_W-1:0] * speed_cmd;
  assign vlim = ctrl_r[CTRL_SPD_EXT] ? spd_prod[OUT_W+ANA_W-1:ANA_W]
              : max_vel_r[OUT_W-1:0];
  // Stroke decel: gain doubles once error falls inside the decel stroke
  assign p_term = $signed({{8{pos_err[POS_W]}}, pos_err}) * $signed({1'b0, gain_r[7:0]});
  assign p_sdd = (abs_err < decel_r[POS_W-1:0]) ? (p_term <<< 1) : p_term;

  always_comb
  begin
    p_clip = ctrl_r[CTRL_NC_MODE] ? OUT_W'(p_term) : OUT_W'(p_sdd);
    if ((ctrl_r[CTRL_NC_MODE] ? p_term : p_sdd) > $signed({1'b0, vlim}))
      p_clip = $signed(vlim);
    else if ((ctrl_r[CTRL_NC_MODE] ? p_term : p_sdd) < -$signed({1'b0, vlim}))
      p_clip = -$signed(vlim);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctl_out_r <= '0;
    else
    begin
      unique case (mode_r)
        APS_OFF: ctl_out_r <= ctrl_r[CTRL_EMERGENCY_OUTPUT_VALUE_EN] ? emergency_output_value_r[OUT_W-1:0] : '0;
        APS_JOG: ctl_out_r <= din_s.jog_pos ? $signed(jog_vel_r[OUT_W-1:0])
                                            : -$signed(jog_vel_r[OUT_W-1:0]);
        default: ctl_out_r <= p_clip;
      endcase
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  logic signed [OUT_W-1:0] pol_out;
  logic [OUT_W+OUT_W-1:0] ma_prod;
  logic [POS_W+OUT_W-1:0] mon_prod;

  assign pol_out = ctrl_r[CTRL_INVERT] ? -ctl_out_r : ctl_out_r;
  // Offset binary of the signed command spans 4..20 mA
  assign ma_prod = ({~pol_out[OUT_W-1], pol_out[OUT_W-2:0]}) * MA_SPAN_CODE;
  assign mon_prod = act_pos_r * {OUT_W{1'b1}};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aout <= '0;
      ready <= 1'b0;
      in_position <= 1'b0;
    end
    else
    begin
      aout.valve <= pol_out;
      aout.current <= MA4_CODE + ma_prod[2*OUT_W-1:OUT_W];
      aout.current_mode <= ctrl_r[CTRL_CUR_MODE];
      // Monitor maps the full 24-bit position range, not stroke, via 24-bit truncation
      aout.monitor <= mon_prod[POS_W+OUT_W-1:POS_W];
      aout.valve_active <= din_s.enable && (mode_r != APS_OFF || ctrl_r[CTRL_EMERGENCY_OUTPUT_VALUE_EN]);
      ready <= din_s.enable && !sensor_err;
      in_position <= din_s.start && (mode_r == APS_RUN)
                   && (abs_err <= window_r[POS_W-1:0]);
    end
  end

endmodule : aps_axis_seq

// ==== bench/aps_axis_seq_chk.sv ====
module aps_axis_seq_chk
  import aps_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire aps_din_s din,
  input wire logic ssi_clk,
  input wire logic ready,
  input wire logic in_position,
  input wire aps_aout_s aout,
  input wire logic sensor_err
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ********
  // Bus
  // ********
  bus_no_wait_a: assert property (psel |-> pready)
    else $error("pready low during a transfer");
  bus_unmapped_a: assert property (psel && penable && paddr > 8'h2C |-> pslverr)
    else $error("no error response for unmapped address");

  // ********
  // Status outputs
  // ********
  rdy_sensor_a: assert property (sensor_err [*2] |-> !ready)
    else $error("ready high with sensor error");
  rdy_enable_a: assert property (!din.enable [*5] |-> !ready)
    else $error("ready high without enable");
  rdy_ok_a: assert property ((din.enable && !sensor_err) [*5] |-> ready)
    else $error("ready low while enabled and healthy");
  inpos_start_a: assert property (!din.start [*5] |-> !in_position)
    else $error("in-position high with start off");
  valve_on_a: assert property (din.enable [*5] |-> aout.valve_active)
    else $error("valve output inactive while enabled");
  cur_span_a: assert property (aout.current_mode && aout.valve_active |->
    aout.current >= MA4_CODE) else $error("current code below 4 mA");

  // ********
  // Serial clock timing
  // ********
  clk_lo_min_a: assert property ($fell(ssi_clk) |-> !ssi_clk [*8])
    else $error("serial clock low phase too short");
  clk_hi_min_a: assert property ($rose(ssi_clk) |-> ssi_clk [*8])
    else $error("serial clock high phase too short");
  clk_lo_max_a: assert property ($fell(ssi_clk) |-> ##[1:700] ssi_clk)
    else $error("serial clock stuck low");
endmodule : aps_axis_seq_chk

bind aps_axis_seq aps_axis_seq_chk i_chk (.pclk, .presetn, .psel, .penable, .paddr, .pready,
  .pslverr, .din, .ssi_clk, .ready, .in_position, .aout, .sensor_err);

// ==== bench/aps_ssi_sensor.sv ====
module aps_ssi_sensor
(
  input wire logic pclk,
  input wire logic ssi_clk,
  input wire logic [4:0] nbits,
  input wire logic [31:0] pos,
  input wire logic fault,
  output logic ssi_data,
  output int frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] sh_r = 32'h0;
  logic clk_d = 1'b1;
  int hi_cnt = 2000;

  initial ssi_data = 1'b1;
  initial frames = 0;

  // Long high clock marks the gap; a fall after it starts a frame
  always @(posedge pclk)
  begin
    clk_d <= ssi_clk;
    hi_cnt <= ssi_clk ? hi_cnt + 1 : 0;
    if (clk_d && !ssi_clk && hi_cnt > 1000)
    begin
      sh_r <= pos << (32 - int'(nbits));
      frames <= frames + 1;
    end
    else if (!clk_d && ssi_clk)
    begin
      // Zeros shift in; the line keeps the last bit until the high gap passes 1000 cycles
      ssi_data <= fault ? 1'b0 : sh_r[31];
      sh_r <= sh_r << 1;
    end
    else if (hi_cnt > 1000)
      ssi_data <= !fault;
  end
endmodule : aps_ssi_sensor

// ==== bench/aps_axis_seq_tb.sv ====
module aps_axis_seq_tb
  import aps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ssi_data, ssi_clk;
  logic ready, in_position, cmd_cable_err, sensor_err, fault, err_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, spos, v;
  logic [4:0] nbits;
  logic [15:0] pcmd;
  logic [63:0] note;
  logic [63:0] exp_q[$];
  aps_din_s din;
  aps_aout_s aout;
  int frames, num_errors, n_tests, n;
  logic [7:0] ra[9] = '{ADDR_CTRL, ADDR_SSI_CFG, ADDR_WINDOW, ADDR_JOG_VEL, ADDR_MAX_VEL,
    ADDR_STROKE, ADDR_DECEL, ADDR_EMERGENCY_OUTPUT_VALUE, ADDR_GAIN};
  logic [31:0] rv[9] = '{CTRL_RST, SSI_CFG_RST, WINDOW_RST, JOG_VEL_RST, MAX_VEL_RST,
    STROKE_RST, DECEL_RST, EMERGENCY_OUTPUT_VALUE_RST, GAIN_RST};

  aps_axis_seq i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .din, .position_command_input(pcmd), .speed_cmd(16'h8000),
    .ana_feedback(16'h8000), .ssi_data, .ssi_clk, .ready, .in_position, .aout,
    .cmd_cable_err, .sensor_err);

  aps_ssi_sensor i_sensor (.pclk, .ssi_clk, .nbits, .pos(spos), .fault, .ssi_data, .frames);

  always #2.5 pclk = ~pclk;

  // ********
  // Checking
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task automatic fail_wait();
    chk(32'h0, 32'h1);
    end_of_test();
  endtask : fail_wait

  // Read results are compared in order against the notes left by the driver
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      chk(prdata & note[63:32], note[31:0]);
    end

  // ********
  // Drivers
  // ********
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] m);
    int k = 0;
    if (!wr)
      exp_q.push_back({m, d & m});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      k++;
      if (k > 50)
        fail_wait();
      @(posedge pclk);
    end
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so the next call never re-drives psel in this step
    @(posedge pclk);
  endtask : apb

  task automatic wait_frames(input int cnt);
    int t = frames + cnt;
    int k = 0;
    while (frames < t)
    begin
      k++;
      if (k > 40000)
        fail_wait();
      @(posedge pclk);
    end
  endtask : wait_frames

  // ********
  // Sequence
  // ********
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    din = '0;
    pcmd = 16'h8000;
    spos = 32'h0;
    nbits = 5'd24;
    fault = 1'b0;
    void'($urandom(32'hEAE3CBA6));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ra[i])
      apb(1'b0, ra[i], rv[i], 32'hFFFF_FFFF);
    apb(1'b1, 8'h30, 32'h0000_00FF, 32'h0);
    chk({31'h0, err_seen}, 32'h1);
    apb(1'b0, 8'h30, 32'h0, 32'hFFFF_FFFF);
    chk({31'h0, err_seen}, 32'h1);
    v = $urandom() & 32'h0000_FFFF;
    apb(1'b1, ADDR_WINDOW, v, 32'h0);
    apb(1'b0, ADDR_WINDOW, v, 32'hFFFF_FFFF);
    $display("test registers done");
    // Short frames keep the run well inside its cycle budget
    apb(1'b1, ADDR_SSI_CFG, 32'h0000_0006, 32'h0);
    nbits <= 5'd6;
    v = $urandom() & 32'h0000_003F;
    spos <= v;
    wait_frames(2);
    apb(1'b0, ADDR_ACT_POS, v, 32'hFFFF_FFFF);
    $display("test binary frame done");
    apb(1'b1, ADDR_CTRL, CTRL_RST | (32'h1 << CTRL_GRAY), 32'h0);
    apb(1'b1, ADDR_SSI_CFG, 32'h0000_0106, 32'h0);
    v = $urandom() & 32'h0000_003F;
    spos <= v ^ (v >> 1);
    wait_frames(2);
    apb(1'b0, ADDR_ACT_POS, v >> 1, 32'hFFFF_FFFF);
    $display("test gray frame done");
    din.enable <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({31'h0, aout.valve_active}, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0000_0011, 32'h0000_003F);
    apb(1'b0, ADDR_CMD_POS, v >> 1, 32'hFFFF_FFFF);
    $display("test enable done");
    din.start <= 1'b1;
    pcmd <= 16'h0100;
    repeat (8) @(posedge pclk);
    chk({31'h0, cmd_cable_err}, 32'h1);
    pcmd <= 16'hC000;
    repeat (8) @(posedge pclk);
    chk({31'h0, cmd_cable_err}, 32'h0);
    // Three quarters of the default stroke
    apb(1'b0, ADDR_CMD_POS, 32'h000B_71B0, 32'hFFFF_FFFF);
    $display("test cable break done");
    din.start <= 1'b0;
    repeat (4) @(posedge pclk);
    // Valve still drives outward, so the target lands one decel stroke ahead
    apb(1'b0, ADDR_CMD_POS, (v >> 1) + DECEL_RST, 32'hFFFF_FFFF);
    $display("test start removal done");
    apb(1'b1, ADDR_EMERGENCY_OUTPUT_VALUE, 32'h0000_1234, 32'h0);
    fault <= 1'b1;
    n = 0;
    while (sensor_err !== 1'b1)
    begin
      n++;
      if (n > 30000)
        fail_wait();
      @(posedge pclk);
    end
    apb(1'b0, ADDR_STATUS, 32'h0000_0004, 32'h0000_0005);
    chk({16'h0, aout.valve}, 32'h0000_1234);
    apb(1'b1, ADDR_CTRL, CTRL_RST | (32'h1 << CTRL_CUR_MODE), 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, aout.current_mode}, 32'h1);
    // 4 mA code plus span times (1234 + half scale) over full scale
    chk({16'h0, aout.current}, 32'h0000_A828);
    $display("test sensor fault done");
    end_of_test();
  end
endmodule : aps_axis_seq_tb
